/* core/sdc_intens_if.sv */
// Signals between the control core and the intensify timer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface sdc_intens_if;
    import sdc_pkg::*;
    logic start;
    logic [CNT_W-1:0] delay_cyc;
    logic [CNT_W-1:0] width_cyc;
    logic active;
    logic busy;
    logic done;
    modport ctrl (output start, output delay_cyc, output width_cyc,
                  input active, input busy, input done);
    modport timer (input start, input delay_cyc, input width_cyc,
                   output active, output busy, output done);
endinterface : sdc_intens_if

/* core/sdc_intens_timer.sv */
// Intensify sequencer: settle delay, then pulse of selected width.
// Assumes counts of at least one cycle and a start pulse only while idle.
`timescale 1ns/1ps
module sdc_intens_timer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    sdc_intens_if.timer tif
);
    import sdc_pkg::*;

    sdc_tstate_t state_reg;
    sdc_tstate_t state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic done_reg;
    logic done_next;

    ////////////////////////////////////////////////////////////////////////
    // next state: delay runs delay_cyc cycles, pulse width_cyc cycles
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        done_next = 1'b0;
        case (state_reg)
            TS_IDLE: begin
                if (tif.start) begin
                    state_next = TS_DELAY;
                    cnt_next = tif.delay_cyc - 1'b1;
                end
            end
            TS_DELAY: begin
                if (cnt_reg == '0) begin
                    state_next = TS_PULSE;
                    cnt_next = tif.width_cyc - 1'b1;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            TS_PULSE: begin
                if (cnt_reg == '0) begin
                    state_next = TS_IDLE;
                    done_next = 1'b1;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = TS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers, frozen while ce is low
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= TS_IDLE;
            cnt_reg <= '0;
            done_reg <= 1'b0;
        end else if (ce) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
        end
    end

    // status back to the core
    assign tif.active = (state_reg == TS_PULSE);
    assign tif.busy = (state_reg != TS_IDLE);
    assign tif.done = done_reg;

endmodule : sdc_intens_timer

/* core/sdc_pkg.sv */
// Constants, register map and types for the storage scope display control.
// Assumes a single 125 MHz clock and a plain strobe register port.
//
// How it works
// - channel-two select output is low exactly while status bit 9 is one.
// - write-through output pulls low while status bit 11 is set.
// - non-store output is high while store bit 10 is set, low otherwise.
// - reset clears all status bits: channel 1, non-store, no erase, no write-through.
// - setting status bit 12 pulls the erase output low to request an erase.
// - erase acknowledge going low clears bit 12, releasing the erase output.
// - while acknowledge stays low, bit 12 is held zero and writes cannot set it.
// - rising edge of erase acknowledge sets the ready flag, status bit 7.
// - intensify waits 20 us, or 80 us with the long-delay jumper.
// - intensify pulse is 2 us wide, or 5 us with the long-width jumper.
// - intensify pulse is negative-going by default; links make it positive-going.
// - setting the erase bit also clears the ready flag.
// - ready set by acknowledge rising edge raises an interrupt, gated by enable and by mask bit 0.
// - the end of every intensify pulse also sets the ready flag.
package sdc_pkg;

    // clock and timing
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned DLY_SHORT_NS = 20000;
    localparam int unsigned DLY_LONG_NS = 80000;
    localparam int unsigned WID_SHORT_NS = 2000;
    localparam int unsigned WID_LONG_NS = 5000;

    // least time: round up, never below one cycle
    function automatic int unsigned sdc_ns_to_cycles(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : sdc_ns_to_cycles

    localparam int unsigned DLY_SHORT_CYC = sdc_ns_to_cycles(DLY_SHORT_NS);
    localparam int unsigned DLY_LONG_CYC = sdc_ns_to_cycles(DLY_LONG_NS);
    localparam int unsigned WID_SHORT_CYC = sdc_ns_to_cycles(WID_SHORT_NS);
    localparam int unsigned WID_LONG_CYC = sdc_ns_to_cycles(WID_LONG_NS);
    localparam int CNT_W = 14;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFF_DSR = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_IST = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_IMK = 4'h8;

    // display status fields
    localparam int BIT_GO = 0;
    localparam int BIT_IE = 6;
    localparam int BIT_RDY = 7;
    localparam int BIT_CH2 = 9;
    localparam int BIT_STORE = 10;
    localparam int BIT_WT = 11;
    localparam int BIT_ERASE = 12;
    localparam logic [DATA_W-1:0] DSR_WMASK = 16'h1E40;
    localparam logic [DATA_W-1:0] DSR_RESET = 16'h0000;

    // interrupt status and mask fields
    localparam int IRQ_W = 2;
    localparam int IRQ_ERASE_DONE = 0;
    localparam int IRQ_INTENS_DONE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

    // pin synchroniser: bit 0 acknowledge, 1 long delay, 2 long width, 3 neg, 4 pos
    localparam int PIN_W = 5;
    localparam logic [PIN_W-1:0] PIN_RESET = 5'h01;

    typedef enum {TS_IDLE, TS_DELAY, TS_PULSE} sdc_tstate_t;

endpackage : sdc_pkg

/* core/sdc_top.sv */
// Storage scope display control: status register, scope logic outputs,
// erase handshake, intensify timing and a maskable interrupt.
// Assumes a same-clock register master and asynchronous scope-side pins.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
module sdc_top #(
    parameter int unsigned DLY_SHORT_P = sdc_pkg::DLY_SHORT_CYC,
    parameter int unsigned DLY_LONG_P = sdc_pkg::DLY_LONG_CYC,
    parameter int unsigned WID_SHORT_P = sdc_pkg::WID_SHORT_CYC,
    parameter int unsigned WID_LONG_P = sdc_pkg::WID_LONG_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [sdc_pkg::ADDR_W-1:0] addr,
    input wire logic [sdc_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [sdc_pkg::DATA_W-1:0] rdata,
    input wire logic erase_ack_n,
    input wire logic long_delay_jumper,
    input wire logic long_width_jumper,
    input wire logic negative_polarity_link,
    input wire logic positive_polarity_link,
    output logic channel_two_select_n,
    output logic write_thru_n_o,
    output logic write_thru_n_oe,
    output logic non_store_n_o,
    output logic non_store_n_oe,
    output logic erase_n_o,
    output logic erase_n_oe,
    output logic intensify,
    output logic irq
);
    import sdc_pkg::*;

    // counts narrowed to the timer width once, here
    localparam logic [CNT_W-1:0] DLY_SHORT_C = CNT_W'(DLY_SHORT_P);
    localparam logic [CNT_W-1:0] DLY_LONG_C = CNT_W'(DLY_LONG_P);
    localparam logic [CNT_W-1:0] WID_SHORT_C = CNT_W'(WID_SHORT_P);
    localparam logic [CNT_W-1:0] WID_LONG_C = CNT_W'(WID_LONG_P);

    sdc_intens_if tif ();

    ////////////////////////////////////////////////////////////////////////
    // pin synchroniser
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1_reg;
    logic [PIN_W-1:0] pin_s2_reg;
    logic [PIN_W-1:0] pin_s3_reg;
    logic [PIN_W-1:0] pin_reg;
    logic [PIN_W-1:0] pin_next;

    assign pin_raw = {positive_polarity_link, negative_polarity_link,
                      long_width_jumper, long_delay_jumper, erase_ack_n};

    // a bit moves only when stages two and three agree; stage one feeds stage two only
    assign pin_next = (pin_s2_reg & pin_s3_reg) | (pin_reg & (pin_s2_reg | pin_s3_reg));

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1_reg <= PIN_RESET;
            pin_s2_reg <= PIN_RESET;
            pin_s3_reg <= PIN_RESET;
            pin_reg <= PIN_RESET;
        end else if (ce) begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
            pin_s3_reg <= pin_s2_reg;
            pin_reg <= pin_next;
        end
    end

    // acknowledge edges on the filtered level
    logic ack_fall;
    logic ack_rise;
    logic ack_low;
    assign ack_fall = pin_reg[0] & ~pin_next[0];
    assign ack_rise = ~pin_reg[0] & pin_next[0];
    assign ack_low = ~pin_reg[0] | ack_fall; // held from the falling edge on

    // jumper decode; positive only when the link is in and the default cut
    logic pos_pol;
    assign pos_pol = pin_reg[4] & ~pin_reg[3];

    ////////////////////////////////////////////////////////////////////////
    // register port decode
    logic hit_dsr;
    logic hit_ist;
    logic hit_imk;
    logic wr_dsr;
    logic rd_ist;
    logic go_req;
    logic erase_set;
    assign hit_dsr = (addr == OFF_DSR);
    assign hit_ist = (addr == OFF_IST);
    assign hit_imk = (addr == OFF_IMK);
    assign wr_dsr = wr & hit_dsr;
    assign rd_ist = rd & hit_ist;
    // a start while the timer runs is dropped, not queued
    assign go_req = wr_dsr & wdata[BIT_GO] & ~tif.busy;
    // an erase request is refused while the scope is still erasing
    assign erase_set = wr_dsr & wdata[BIT_ERASE] & ~ack_low;

    ////////////////////////////////////////////////////////////////////////
    // display status register
    logic [DATA_W-1:0] dsr_reg;
    logic [DATA_W-1:0] dsr_next;
    logic rdy_set;
    logic rdy_clr;
    assign rdy_set = ack_rise | tif.done;
    assign rdy_clr = erase_set | go_req;

    always_comb begin
        dsr_next = dsr_reg;
        if (wr_dsr) begin
            dsr_next = (dsr_reg & ~DSR_WMASK) | (wdata & DSR_WMASK);
        end
        // erase bit follows the handshake, not the plain write
        if (ack_low) begin
            dsr_next[BIT_ERASE] = 1'b0;
        end else if (wr_dsr) begin
            dsr_next[BIT_ERASE] = erase_set;
        end
        // set wins over clear in the same cycle
        if (rdy_set) begin
            dsr_next[BIT_RDY] = 1'b1;
        end else if (rdy_clr) begin
            dsr_next[BIT_RDY] = 1'b0;
        end
        dsr_next[BIT_GO] = tif.busy | go_req;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dsr_reg <= DSR_RESET;
        end else if (ce) begin
            dsr_reg <= dsr_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt status and mask
    logic [IRQ_W-1:0] ist_reg;
    logic [IRQ_W-1:0] ist_next;
    logic [IRQ_W-1:0] imk_reg;
    logic [IRQ_W-1:0] ev;
    logic irq_next;
    assign ev = {tif.done, ack_rise};
    // read clears, but an event in the same cycle survives
    assign ist_next = (rd_ist ? IRQ_RESET : ist_reg) | ev;
    // level output, gated by the enable bit as well as the mask
    assign irq_next = dsr_next[BIT_IE] & |(ist_next & imk_reg);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ist_reg <= IRQ_RESET;
            imk_reg <= IRQ_RESET;
            irq <= 1'b0;
        end else if (ce) begin
            ist_reg <= ist_next;
            if (wr & hit_imk) begin
                imk_reg <= wdata[IRQ_W-1:0];
            end
            irq <= irq_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, valid the cycle after the strobe only
    logic [DATA_W-1:0] rd_mux;
    assign rd_mux = hit_dsr ? dsr_reg :
                    hit_ist ? {{(DATA_W-IRQ_W){1'b0}}, ist_reg} :
                    hit_imk ? {{(DATA_W-IRQ_W){1'b0}}, imk_reg} :
                    16'h0000;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 16'h0000;
        end else if (ce) begin
            rdata <= rd ? rd_mux : 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // intensify timer
    assign tif.start = go_req;
    assign tif.delay_cyc = pin_reg[1] ? DLY_LONG_C : DLY_SHORT_C;
    assign tif.width_cyc = pin_reg[2] ? WID_LONG_C : WID_SHORT_C;

    sdc_intens_timer u_timer (
        .mclk (mclk),
        .rst_n (rst_n),
        .ce (ce),
        .tif (tif)
    );

    ////////////////////////////////////////////////////////////////////////
    // scope logic outputs; open-collector lines drive low only when enabled
    // write-through does not store; software must keep refreshing points
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            channel_two_select_n <= 1'b1;
            write_thru_n_o <= 1'b0;
            write_thru_n_oe <= 1'b0;
            non_store_n_o <= 1'b0;
            non_store_n_oe <= 1'b1;
            erase_n_o <= 1'b0;
            erase_n_oe <= 1'b0;
            intensify <= 1'b1;
        end else if (ce) begin
            channel_two_select_n <= ~dsr_next[BIT_CH2];
            write_thru_n_oe <= dsr_next[BIT_WT];
            non_store_n_oe <= ~dsr_next[BIT_STORE];
            erase_n_oe <= dsr_next[BIT_ERASE];
            // negative pulse idles high; positive idles low
            intensify <= pos_pol ? tif.active : ~tif.active;
        end
    end

endmodule : sdc_top

/* verification/sdc_props.sv */
// Port-level checks for the storage scope display control.
// Assumes binding onto sdc_top and a bench that changes straps only in reset.
`timescale 1ns/1ps
module sdc_props
    import sdc_pkg::*;
#(
    parameter int unsigned DLY_SHORT_P = DLY_SHORT_CYC,
    parameter int unsigned DLY_LONG_P = DLY_LONG_CYC,
    parameter int unsigned WID_SHORT_P = WID_SHORT_CYC,
    parameter int unsigned WID_LONG_P = WID_LONG_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic erase_ack_n,
    input wire logic long_delay_jumper,
    input wire logic long_width_jumper,
    input wire logic negative_polarity_link,
    input wire logic positive_polarity_link,
    input wire logic channel_two_select_n,
    input wire logic write_thru_n_o,
    input wire logic write_thru_n_oe,
    input wire logic non_store_n_o,
    input wire logic non_store_n_oe,
    input wire logic erase_n_o,
    input wire logic erase_n_oe,
    input wire logic intensify
);
    logic act;
    logic go;
    logic [3:0] live;
    logic [2:0] ack_hi;
    logic [2:0] ack_lo;
    logic [15:0] wcnt;
    logic [15:0] dcnt;

    // pulse active level follows the straps, which settle during reset
    assign act = (positive_polarity_link & ~negative_polarity_link) ? intensify : ~intensify;
    assign go = wr & ce & (addr == OFF_DSR) & wdata[BIT_GO];

    // settle, acknowledge run and pulse counters
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            live <= 4'h0;
            ack_hi <= 3'h0;
            ack_lo <= 3'h0;
            wcnt <= 16'h0000;
            dcnt <= 16'h0000;
        end else begin
            live <= (live == 4'hF) ? live : live + 4'h1;
            ack_hi <= !erase_ack_n ? 3'h0 : (ack_hi == 3'h7) ? ack_hi : ack_hi + 3'h1;
            ack_lo <= erase_ack_n ? 3'h0 : (ack_lo == 3'h7) ? ack_lo : ack_lo + 3'h1;
            wcnt <= act ? wcnt + 16'h0001 : 16'h0000;
            dcnt <= go ? 16'h0001 : act ? 16'h0000 : (dcnt != 16'h0000) ? dcnt + 16'h0001 : dcnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_ch2_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && ce && addr == OFF_DSR |-> ##2 channel_two_select_n == !$past(wdata[BIT_CH2], 2))
        else $error("channel select does not follow bit 9");
    chk_wt_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && ce && addr == OFF_DSR |-> ##2 write_thru_n_oe == $past(wdata[BIT_WT], 2))
        else $error("write-through does not follow bit 11");
    chk_store_follows: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && ce && addr == OFF_DSR |-> ##2 non_store_n_oe == !$past(wdata[BIT_STORE], 2))
        else $error("non-store does not follow bit 10");
    chk_erase_request: assert property (@(posedge mclk) disable iff (!rst_n)
        wr && ce && addr == OFF_DSR && wdata[BIT_ERASE] && ack_hi >= 3'h5 |-> ##2 erase_n_oe)
        else $error("erase request not driven");
    chk_erase_held: assert property (@(posedge mclk) disable iff (!rst_n)
        ack_lo >= 3'h5 |-> !erase_n_oe)
        else $error("erase driven while acknowledge low");
    chk_rdata_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !$past(rd) |-> rdata == 16'h0000)
        else $error("read data outside its cycle");
    chk_open_coll: assert property (@(posedge mclk) disable iff (!rst_n)
        !(erase_n_o | write_thru_n_o | non_store_n_o))
        else $error("open-collector data not low");
    chk_pulse_width: assert property (@(posedge mclk) disable iff (!rst_n)
        live == 4'hF && !act && $past(act) |->
        wcnt == (long_width_jumper ? WID_LONG_P : WID_SHORT_P))
        else $error("intensify width wrong");
    chk_pulse_delay: assert property (@(posedge mclk) disable iff (!rst_n)
        live == 4'hF && act && !$past(act) |->
        dcnt >= (long_delay_jumper ? DLY_LONG_P : DLY_SHORT_P) &&
        dcnt <= (long_delay_jumper ? DLY_LONG_P : DLY_SHORT_P) + 4)
        else $error("intensify delay wrong");
endmodule : sdc_props

bind sdc_top sdc_props #(.DLY_SHORT_P(DLY_SHORT_P), .DLY_LONG_P(DLY_LONG_P),
    .WID_SHORT_P(WID_SHORT_P), .WID_LONG_P(WID_LONG_P)) u_props (.*);

/* verification/sdc_scope_model.sv */
// Storage scope stand-in: answers an erase request with an acknowledge.
// Assumes the bench resolves the open-collector erase line with a pull-up.
`timescale 1ns/1ps
module sdc_scope_model #(
    parameter int ACK_DLY = 10,
    parameter int ERASE_CYC = 60
) (
    input wire logic mclk,
    input wire logic erase_line_n,
    output logic erase_ack_n
);
    // no point memory: with write-through on nothing is kept, software refreshes
    // erase: acknowledge stays low for the whole interval, then releases
    initial begin
        erase_ack_n = 1'b1;
        forever begin
            @(posedge mclk);
            if (erase_line_n === 1'b0) begin
                repeat (ACK_DLY) @(posedge mclk);
                erase_ack_n <= 1'b0;
                repeat (ERASE_CYC) @(posedge mclk);
                erase_ack_n <= 1'b1;
            end
        end
    end
endmodule : sdc_scope_model

/* verification/sdc_top_bench.sv */
// Self-checking bench for the storage scope display control.
// Assumes short timing parameters; reads are checked from a queue of notes.
`timescale 1ns/1ps
module sdc_top_bench;
    import sdc_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
    logic long_delay_jumper = 1'b0, long_width_jumper = 1'b0;
    logic negative_polarity_link = 1'b1, positive_polarity_link = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic channel_two_select_n, write_thru_n_o, write_thru_n_oe, non_store_n_o;
    logic non_store_n_oe, erase_n_o, erase_n_oe, intensify, irq, erase_ack_n, erase_line_n;
    logic [DATA_W-1:0] exp_q[$];
    logic [31:0] seed = 32'h1F917F32;
    int num_errors = 0, comparisons = 0;

    always #4 mclk = ~mclk;
    // open-collector erase line with its pull-up
    assign erase_line_n = erase_n_oe ? erase_n_o : 1'b1;

    sdc_top #(.DLY_SHORT_P(20), .DLY_LONG_P(40), .WID_SHORT_P(4), .WID_LONG_P(6)) dut (.*);
    sdc_scope_model scope (.mclk(mclk), .erase_line_n(erase_line_n), .erase_ack_n(erase_ack_n));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    task automatic chk_val(input string what, input logic [DATA_W-1:0] e,
                           input logic [DATA_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_val

    task automatic chk_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %b seen %b", what, e, g);
        end
    endtask : chk_bit

    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk);
        rd <= 1'b0;
    endtask : rd_reg

    // straps only change inside reset, where their filters restart
    task automatic do_reset(input logic pos);
        @(posedge mclk);
        rst_n <= 1'b0;
        positive_polarity_link <= pos;
        negative_polarity_link <= !pos;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        @(negedge mclk);
    endtask : do_reset

    task automatic pulse(input logic ld, input logic lw, input logic pos, input logic ie);
        int i;
        int w;
        @(posedge mclk);
        long_delay_jumper <= ld;
        long_width_jumper <= lw;
        repeat (6) @(posedge mclk);
        wr_reg(OFF_DSR, 16'h0041);
        for (i = 0; i < 200 && intensify !== pos; i++) @(negedge mclk);
        w = 0;
        while (intensify === pos && w < 100) begin
            w++;
            @(negedge mclk);
        end
        chk_val("width", lw ? 16'h0006 : 16'h0004, w[15:0]);
        @(negedge mclk);
        chk_bit("irq", ie, irq);
        rd_reg(OFF_DSR, 16'h00C0);
        rd_reg(OFF_IST, 16'h0002);
        repeat (2) @(negedge mclk);
        chk_bit("irq", 1'b0, irq);
    endtask : pulse

    task automatic give_verdict();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    ////////////////////////////////////////////////////////////////////////////
    // read monitor: oldest note against the data cycle
    always @(posedge mclk) rd_q <= rd;
    always @(negedge mclk) begin
        if (rd_q) begin
            chk_val("rdata", exp_q.pop_front(), rdata);
        end
    end

    // watchdog: a hang counts as a mismatch
    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        give_verdict();
    end

    initial begin
        logic [DATA_W-1:0] v;
        int i;
        do_reset(1'b0);
        chk_bit("ch2", 1'b1, channel_two_select_n);
        chk_bit("wt", 1'b0, write_thru_n_oe);
        chk_bit("ns", 1'b1, non_store_n_oe);
        chk_bit("erase", 1'b0, erase_n_oe);
        rd_reg(OFF_DSR, 16'h0000);
        rd_reg(OFF_IST, 16'h0000);
        rd_reg(4'hC, 16'h0000);
        // random mode bits, read back right behind the write
        for (i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed[15:0] & 16'h0E00;
            wr_reg(OFF_DSR, v);
            @(posedge mclk);
            @(negedge mclk);
            chk_bit("ch2", !v[BIT_CH2], channel_two_select_n);
            chk_bit("wt", v[BIT_WT], write_thru_n_oe);
            chk_bit("ns", !v[BIT_STORE], non_store_n_oe);
            rd_reg(OFF_DSR, v);
        end
        // clock enable low: the write is lost; idle one cycle first so rdata is back at zero
        @(posedge mclk);
        ce <= 1'b0;
        wr_reg(OFF_DSR, v ^ 16'h0E00);
        ce <= 1'b1;
        rd_reg(OFF_DSR, v);
        wr_reg(OFF_IMK, 16'h0003);
        for (i = 0; i < 4; i++) pulse(i[0], i[1], 1'b0, 1'b1);
        wr_reg(OFF_IMK, 16'h0001);
        pulse(1'b0, 1'b0, 1'b0, 1'b0);
        do_reset(1'b1);
        chk_bit("idle", 1'b0, intensify);
        wr_reg(OFF_IMK, 16'h0003);
        pulse(1'b1, 1'b1, 1'b1, 1'b1);
        // erase handshake with a refused request in mid-erase
        wr_reg(OFF_DSR, 16'h1040);
        @(posedge mclk);
        @(negedge mclk);
        chk_bit("erase", 1'b1, erase_n_oe);
        rd_reg(OFF_DSR, 16'h1040);
        for (i = 0; i < 100 && erase_n_oe !== 1'b0; i++) @(negedge mclk);
        chk_bit("erase", 1'b0, erase_n_oe);
        repeat (4) @(posedge mclk);
        wr_reg(OFF_DSR, 16'h1040);
        repeat (2) @(negedge mclk);
        chk_bit("erase", 1'b0, erase_n_oe);
        rd_reg(OFF_DSR, 16'h0040);
        for (i = 0; i < 200 && irq !== 1'b1; i++) @(negedge mclk);
        chk_bit("irq", 1'b1, irq);
        rd_reg(OFF_DSR, 16'h00C0);
        rd_reg(OFF_IST, 16'h0001);
        repeat (3) @(posedge mclk);
        give_verdict();
    end
endmodule : sdc_top_bench
